// ### rtl/ppsc_map.svh
// offsets, codes and timing counts of the platform power-state controller
`ifndef PPSC_MAP_SVH
`define PPSC_MAP_SVH

`define PPSC_CLK_MHZ 100
`define PPSC_CLK_PERIOD_NS 10

// power button hold time before the press is passed on to the host
`define PPSC_BTN_HOLD_MS 4
`define PPSC_BTN_HOLD_CYCLES (`PPSC_BTN_HOLD_MS * 1000 * `PPSC_CLK_MHZ)

`define PPSC_RAIL_W 8
`define PPSC_LIST_W 3
`define PPSC_STEP_W 4

// task list identifiers
`define PPSC_LIST_COLD_BOOT 3'h0
`define PPSC_LIST_COLD_OFF 3'h1
`define PPSC_LIST_SHALLOW_ENTRY 3'h2
`define PPSC_LIST_SHALLOW_EXIT 3'h3
`define PPSC_LIST_SLEEP_ENTRY 3'h4
`define PPSC_LIST_SLEEP_EXIT 3'h5
`define PPSC_LIST_DEEP_ENTRY 3'h6

// task list lengths in steps, one step per clock
`define PPSC_LEN_COLD_BOOT 4'h8
`define PPSC_LEN_COLD_OFF 4'h6
`define PPSC_LEN_SHALLOW_ENTRY 4'h3
`define PPSC_LEN_SHALLOW_EXIT 4'h3
`define PPSC_LEN_SLEEP_ENTRY 4'h4
`define PPSC_LEN_SLEEP_EXIT 4'h4
`define PPSC_LEN_DEEP_ENTRY 4'h5

// synchroniser bit positions
`define PPSC_SB_BTN_N 0
`define PPSC_SB_ENABLE 1
`define PPSC_SB_PLTRST_N 2
`define PPSC_SB_SHALLOW_N 3
`define PPSC_SB_SLEEP_N 4
`define PPSC_SB_DEEP_N 5
`define PPSC_SB_SUSP_ACK 6
`define PPSC_SB_ABOVE_RISE 7
`define PPSC_SB_BELOW_FALL 8
`define PPSC_SB_W 9
// idle level of each synchronised input after reset
`define PPSC_SB_INIT 9'h03d

`endif

// ### rtl/ppsc_pkg.sv
// types of the platform power-state controller
package ppsc_pkg;

    typedef enum logic [5:0] {
        PS_FULL_OFF = 6'h01,
        PS_STBY_OFF = 6'h02,
        PS_RUNNING = 6'h04,
        PS_SHALLOW = 6'h08,
        PS_SLEEP = 6'h10,
        PS_DEEP = 6'h20
    } ppsc_state_type;

endpackage

// ### rtl/ppsc_sync.sv
// two-stage synchroniser for the asynchronous sideband inputs
`timescale 1ns/1ns
module ppsc_sync #(
    parameter int WIDTH = 9,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw inputs
    output logic [WIDTH-1:0] sync_out // synchronised inputs
);
    logic [WIDTH-1:0] stage1_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    stage1_reg[i] <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    stage1_reg[i] <= async_in[i];
                    sync_out[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate
endmodule

// ### rtl/ppsc_task_engine.sv
// task list sequencer: idle until started, steps through one list, idles
`timescale 1ns/1ns
`include "ppsc_map.svh"
module ppsc_task_engine (
    input wire logic clk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic start, // one-cycle start pulse
    input wire logic [`PPSC_LIST_W-1:0] list_in, // list to run
    input wire logic abort, // stop at once, no further steps
    output logic busy_reg, // a list is running
    output logic [`PPSC_LIST_W-1:0] list_reg, // list being run
    output logic [`PPSC_STEP_W-1:0] step_reg, // current step
    output logic done_reg // one-cycle pulse after the last step
);
    logic [`PPSC_STEP_W-1:0] last_step;

    always_comb case (list_reg)
        `PPSC_LIST_COLD_BOOT: last_step = `PPSC_LEN_COLD_BOOT - 4'h1;
        `PPSC_LIST_COLD_OFF: last_step = `PPSC_LEN_COLD_OFF - 4'h1;
        `PPSC_LIST_SHALLOW_ENTRY: last_step = `PPSC_LEN_SHALLOW_ENTRY - 4'h1;
        `PPSC_LIST_SHALLOW_EXIT: last_step = `PPSC_LEN_SHALLOW_EXIT - 4'h1;
        `PPSC_LIST_SLEEP_ENTRY: last_step = `PPSC_LEN_SLEEP_ENTRY - 4'h1;
        `PPSC_LIST_SLEEP_EXIT: last_step = `PPSC_LEN_SLEEP_EXIT - 4'h1;
        default: last_step = `PPSC_LEN_DEEP_ENTRY - 4'h1;
    endcase

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            list_reg <= `PPSC_LIST_COLD_BOOT;
            step_reg <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (abort) begin
                busy_reg <= 1'b0;
                step_reg <= 4'h0;
            end else if (!busy_reg && start) begin
                busy_reg <= 1'b1;
                list_reg <= list_in;
                step_reg <= 4'h0;
            end else if (busy_reg) begin
                if (step_reg == last_step) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    step_reg <= 4'h0;
                end else begin
                    step_reg <= step_reg + 4'h1;
                end
            end
        end
    end
endmodule

// ### rtl/ppsc_top.sv
// platform power-state controller: six states, sideband and task lists
// Notes on behaviour
// - supply valid once above rising threshold
// - supply invalid once below falling threshold
// - supply validity moves full-off to standby-off
// - six states with own reset, power-good levels
// - running: rails up, reset released, power-good
// - sleep, deep sleep: reset held, power-good low
// - shallow: reset released, slow thermal sampling
// - full-off: nothing active, left on valid supply
// - supply valid from full-off: standby, map reset
// - standby-off waits for button or enable
// - supply loss forces full-off, logic defaults
// - button or enable boots cold into deep
// - host commands act in running state
// - thermal critical: rails off, standby, no list
// - other critical: run cold-off list in running, shallow and sleep
// - held button passed to host
// - shallow request low: entry list, shallow
// - each standby state has own entry list
// - shallow: power-save, buses and registers kept
// - shallow request high: exit list, running
// - task engine idle, runs list, returns idle
`timescale 1ns/1ns
`include "ppsc_map.svh"
module ppsc_top #(
    parameter int RAIL_W = `PPSC_RAIL_W,
    parameter int BTN_HOLD_CYCLES = `PPSC_BTN_HOLD_CYCLES
) (
    input wire logic clk, // 100 MHz controller clock
    input wire logic rstn, // async reset, active low
    input wire logic supply_above_rise, // main supply over rising threshold
    input wire logic supply_below_fall, // main supply under falling threshold
    input wire logic power_button_in_n, // power button, low when pressed
    input wire logic external_enable_in, // external enable
    input wire logic platform_reset_n_in, // platform reset pin level
    input wire logic shallow_sleep_req_n, // shallow sleep request
    input wire logic sleep_req_n, // sleep request
    input wire logic deep_sleep_req_n, // deep sleep request
    input wire logic suspend_powerdown_ack, // host power-down acknowledge
    input wire logic thermal_crit, // thermal critical event
    input wire logic nonthermal_crit, // other critical event
    input wire logic rail_cmd_valid, // host rail command strobe
    input wire logic [RAIL_W-1:0] rail_cmd, // default-off rail enables
    output logic platform_reset_n_out, // reset pin drive level
    output logic platform_reset_n_oe, // reset pin driven low
    output logic core_power_good, // core power-good
    output logic host_rails_on, // host rails in regulation
    output logic [RAIL_W-1:0] default_off_rails, // software rails
    output logic power_save_mode, // regulators in power-save mode
    output logic bus_enable, // serial bus and voltage link active
    output logic bus_reset, // pulse: reset bus and voltage link
    output logic regmap_reset, // pulse: register map to defaults
    output logic logic_defaults_reset, // pulse: standby logic defaults
    output logic thermal_mon_enable, // thermal monitor running
    output logic thermal_mon_standby, // thermal monitor slow sampling
    output logic button_to_host_n, // button level passed to host
    output logic supply_valid, // main supply judged valid
    output logic task_busy, // a task list runs
    output logic [`PPSC_LIST_W-1:0] task_list, // list running
    output logic [`PPSC_STEP_W-1:0] task_step, // step within list
    output logic task_done, // pulse after last step
    output logic [5:0] power_state // one-hot platform state
);
    logic [`PPSC_SB_W-1:0] sb;
    logic btn_prev_reg;
    logic en_prev_reg;
    logic pltrst_prev_reg;
    logic [31:0] hold_cnt_reg;
    logic btn_held_reg;
    logic supply_valid_reg;
    ppsc_pkg::ppsc_state_type state_reg;
    ppsc_pkg::ppsc_state_type state_next;
    ppsc_pkg::ppsc_state_type target_reg;
    logic start_next;
    logic [`PPSC_LIST_W-1:0] list_next;
    ppsc_pkg::ppsc_state_type target_next;
    logic engine_abort;
    logic btn_pressed;
    logic btn_press_edge;
    logic en_rise_edge;
    logic warm_reset_edge;
    logic supply_lost;
    logic supply_gained;
    logic thermal_shut;

    ppsc_sync #(
        .WIDTH(`PPSC_SB_W),
        .INIT(`PPSC_SB_INIT)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({supply_below_fall, supply_above_rise,
                   suspend_powerdown_ack, deep_sleep_req_n, sleep_req_n,
                   shallow_sleep_req_n, platform_reset_n_in,
                   external_enable_in, power_button_in_n}),
        .sync_out(sb)
    );

    ppsc_task_engine u_engine (
        .clk(clk),
        .rstn(rstn),
        .start(start_next),
        .list_in(list_next),
        .abort(engine_abort),
        .busy_reg(task_busy),
        .list_reg(task_list),
        .step_reg(task_step),
        .done_reg(task_done)
    );

    // hysteresis lives in the comparator; here the flag only latches it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            supply_valid_reg <= 1'b0;
        end else if (sb[`PPSC_SB_BELOW_FALL]) begin
            supply_valid_reg <= 1'b0;
        end else if (sb[`PPSC_SB_ABOVE_RISE]) begin
            supply_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            btn_prev_reg <= 1'b1;
            en_prev_reg <= 1'b0;
            pltrst_prev_reg <= 1'b1;
        end else begin
            btn_prev_reg <= sb[`PPSC_SB_BTN_N];
            en_prev_reg <= sb[`PPSC_SB_ENABLE];
            pltrst_prev_reg <= sb[`PPSC_SB_PLTRST_N];
        end
    end

    assign btn_pressed = !sb[`PPSC_SB_BTN_N];
    assign btn_press_edge = btn_prev_reg && !sb[`PPSC_SB_BTN_N];
    assign en_rise_edge = !en_prev_reg && sb[`PPSC_SB_ENABLE];
    // the pin reads low in sleep states because we drive it; only count it
    // as a warm reset while released in running
    assign warm_reset_edge = (state_reg == ppsc_pkg::PS_RUNNING) &&
                             pltrst_prev_reg && !sb[`PPSC_SB_PLTRST_N];
    assign supply_lost = (state_reg != ppsc_pkg::PS_FULL_OFF) &&
                         !supply_valid_reg;
    assign supply_gained = (state_reg == ppsc_pkg::PS_FULL_OFF) &&
                           supply_valid_reg;
    assign thermal_shut = thermal_crit &&
                          (state_reg != ppsc_pkg::PS_FULL_OFF) &&
                          (state_reg != ppsc_pkg::PS_STBY_OFF);
    assign engine_abort = supply_lost || thermal_shut;

    // button hold timer runs in every state but full-off and standby-off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt_reg <= 32'h0;
            btn_held_reg <= 1'b0;
        end else if (!btn_pressed || state_reg == ppsc_pkg::PS_FULL_OFF ||
                     state_reg == ppsc_pkg::PS_STBY_OFF) begin
            hold_cnt_reg <= 32'h0;
            btn_held_reg <= 1'b0;
        end else if (hold_cnt_reg >= 32'(BTN_HOLD_CYCLES - 1)) begin
            btn_held_reg <= 1'b1;
        end else begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end

    // next-state choice; list-driven moves complete on the engine's done
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        list_next = `PPSC_LIST_COLD_BOOT;
        target_next = target_reg;
        if (supply_gained) begin
            state_next = ppsc_pkg::PS_STBY_OFF;
        end else if (supply_lost) begin
            state_next = ppsc_pkg::PS_FULL_OFF;
        end else if (thermal_shut) begin
            state_next = ppsc_pkg::PS_STBY_OFF;
        end else if (task_done) begin
            state_next = target_reg;
        end else if (!task_busy) begin
            case (state_reg)
                ppsc_pkg::PS_FULL_OFF: begin
                    state_next = state_reg;
                end
                ppsc_pkg::PS_STBY_OFF: begin
                    if (btn_press_edge || en_rise_edge) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_COLD_BOOT;
                        target_next = ppsc_pkg::PS_DEEP;
                    end
                end
                ppsc_pkg::PS_RUNNING: begin
                    if (nonthermal_crit) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_COLD_OFF;
                        target_next = ppsc_pkg::PS_STBY_OFF;
                    end else if (!sb[`PPSC_SB_SHALLOW_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_SHALLOW_ENTRY;
                        target_next = ppsc_pkg::PS_SHALLOW;
                    end else if (!sb[`PPSC_SB_SLEEP_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_SLEEP_ENTRY;
                        target_next = ppsc_pkg::PS_SLEEP;
                    end
                end
                ppsc_pkg::PS_SHALLOW: begin
                    if (nonthermal_crit) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_COLD_OFF;
                        target_next = ppsc_pkg::PS_STBY_OFF;
                    end else if (sb[`PPSC_SB_SHALLOW_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_SHALLOW_EXIT;
                        target_next = ppsc_pkg::PS_RUNNING;
                    end else if (!sb[`PPSC_SB_SLEEP_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_SLEEP_ENTRY;
                        target_next = ppsc_pkg::PS_SLEEP;
                    end
                end
                ppsc_pkg::PS_SLEEP: begin
                    if (nonthermal_crit) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_COLD_OFF;
                        target_next = ppsc_pkg::PS_STBY_OFF;
                    end else if (!sb[`PPSC_SB_DEEP_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_DEEP_ENTRY;
                        target_next = ppsc_pkg::PS_DEEP;
                    end else if (sb[`PPSC_SB_SLEEP_N]) begin
                        start_next = 1'b1;
                        list_next = `PPSC_LIST_SLEEP_EXIT;
                        target_next = ppsc_pkg::PS_RUNNING;
                    end
                end
                ppsc_pkg::PS_DEEP: begin
                    // deep exit lists are outside this block: step to sleep
                    if (sb[`PPSC_SB_SUSP_ACK]) begin
                        state_next = ppsc_pkg::PS_STBY_OFF;
                    end else if (sb[`PPSC_SB_DEEP_N]) begin
                        state_next = ppsc_pkg::PS_SLEEP;
                    end
                end
                default: begin
                    state_next = ppsc_pkg::PS_FULL_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ppsc_pkg::PS_FULL_OFF;
            target_reg <= ppsc_pkg::PS_FULL_OFF;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
        end
    end

    // sideband levels per state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            platform_reset_n_out <= 1'b0;
            platform_reset_n_oe <= 1'b1;
            core_power_good <= 1'b0;
            host_rails_on <= 1'b0;
            power_save_mode <= 1'b0;
            bus_enable <= 1'b0;
            thermal_mon_enable <= 1'b0;
            thermal_mon_standby <= 1'b0;
        end else begin
            platform_reset_n_out <= 1'b0;
            case (state_next)
                ppsc_pkg::PS_RUNNING: begin
                    platform_reset_n_oe <= 1'b0;
                    core_power_good <= 1'b1;
                    host_rails_on <= 1'b1;
                    power_save_mode <= 1'b0;
                    bus_enable <= 1'b1;
                    thermal_mon_enable <= 1'b1;
                    thermal_mon_standby <= 1'b0;
                end
                ppsc_pkg::PS_SHALLOW: begin
                    platform_reset_n_oe <= 1'b0;
                    core_power_good <= 1'b1;
                    host_rails_on <= 1'b1;
                    power_save_mode <= 1'b1;
                    bus_enable <= 1'b1;
                    thermal_mon_enable <= 1'b1;
                    thermal_mon_standby <= 1'b1;
                end
                ppsc_pkg::PS_SLEEP, ppsc_pkg::PS_DEEP: begin
                    platform_reset_n_oe <= 1'b1;
                    core_power_good <= 1'b0;
                    host_rails_on <= 1'b0;
                    power_save_mode <= 1'b1;
                    bus_enable <= 1'b0;
                    thermal_mon_enable <= 1'b0;
                    thermal_mon_standby <= 1'b0;
                end
                default: begin
                    // full-off and standby-off: all rails down, reset held
                    platform_reset_n_oe <= 1'b1;
                    core_power_good <= 1'b0;
                    host_rails_on <= 1'b0;
                    power_save_mode <= 1'b0;
                    bus_enable <= 1'b0;
                    thermal_mon_enable <= 1'b0;
                    thermal_mon_standby <= 1'b0;
                end
            endcase
        end
    end

    // software rails follow host commands only while running; they are
    // cleared whenever the host rails go down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            default_off_rails <= '0;
        end else if (state_next != ppsc_pkg::PS_RUNNING &&
                     state_next != ppsc_pkg::PS_SHALLOW) begin
            default_off_rails <= '0;
        end else if (rail_cmd_valid &&
                     state_reg == ppsc_pkg::PS_RUNNING) begin
            default_off_rails <= rail_cmd;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_reset <= 1'b0;
            regmap_reset <= 1'b0;
            logic_defaults_reset <= 1'b0;
        end else begin
            bus_reset <= warm_reset_edge && !supply_lost;
            regmap_reset <= supply_gained;
            logic_defaults_reset <= supply_lost;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            button_to_host_n <= 1'b1;
            supply_valid <= 1'b0;
            power_state <= 6'h01;
        end else begin
            button_to_host_n <= !(btn_held_reg && btn_pressed);
            supply_valid <= supply_valid_reg;
            power_state <= state_next;
        end
    end
endmodule

// ### testbench/ppsc_top_asserts.sv
// port-level assertions of the platform power-state controller
`timescale 1ns/1ns
module ppsc_top_asserts (
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic supply_above_rise, // rise comparator
    input wire logic supply_below_fall, // fall comparator
    input wire logic thermal_crit, // thermal event
    input wire logic platform_reset_n_oe, // reset drive
    input wire logic core_power_good, // power-good
    input wire logic regmap_reset, // map reset pulse
    input wire logic supply_valid, // supply judged valid
    input wire logic task_busy, // list running
    input wire logic task_done, // list end pulse
    input wire logic [5:0] power_state // one-hot state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_run_levels: assert property (power_state == 6'h04 |->
        !platform_reset_n_oe && core_power_good) else $error("run levels");
    chk_sleep_levels: assert property (
        power_state inside {6'h10, 6'h20} |->
        platform_reset_n_oe && !core_power_good) else $error("sleep levels");
    chk_shallow_levels: assert property (power_state == 6'h08 |->
        !platform_reset_n_oe && core_power_good) else $error("shallow");
    // six samples leave room for two sync stages, the flag and the state
    chk_supply_loss: assert property (supply_below_fall [*6] |->
        power_state == 6'h01 && !supply_valid) else $error("supply loss");
    chk_supply_gain: assert property (
        (supply_above_rise && !supply_below_fall) [*6] |-> supply_valid)
        else $error("supply not valid");
    chk_map_reset: assert property ($past(power_state) == 6'h01 &&
        power_state == 6'h02 |-> regmap_reset) else $error("no map reset");
    chk_thermal_off: assert property (
        power_state == 6'h04 && thermal_crit && !supply_below_fall |->
        ##[1:2] power_state == 6'h02) else $error("thermal shutdown");
    chk_done_idle: assert property (task_done |-> $past(task_busy))
        else $error("done without list");
    cover property (power_state == 6'h08);
    cover property (power_state == 6'h04 && thermal_crit);
    cover property (task_done && power_state == 6'h04);
endmodule

bind ppsc_top ppsc_top_asserts i_ppsc_top_asserts (.clk, .rstn,
    .supply_above_rise, .supply_below_fall, .thermal_crit,
    .platform_reset_n_oe, .core_power_good, .regmap_reset, .supply_valid,
    .task_busy, .task_done, .power_state);

// ### testbench/ppsc_host_model.sv
// behavioural host driving the sleep sideband of the controller
`timescale 1ns/1ns
module ppsc_host_model #(
    parameter int GAP = 12
) (
    input wire logic clk, // clock
    input wire logic [1:0] want, // 0 run, 1 shallow, 2 power off
    output logic shallow_sleep_req_n, // shallow request
    output logic sleep_req_n, // sleep request
    output logic deep_sleep_req_n, // deep request
    output logic suspend_powerdown_ack // power-down acknowledge
);
    int gap_cnt = 0;
    initial {shallow_sleep_req_n, sleep_req_n, deep_sleep_req_n} = 3'h7;
    initial suspend_powerdown_ack = 1'b0;
    // each power-off step waits so that the entry list before it ends
    always @(posedge clk) begin
        #1;
        if (gap_cnt != 0) gap_cnt--;
        else if (want == 2'd1) shallow_sleep_req_n = 1'b0;
        else if (want == 2'd0) begin
            {shallow_sleep_req_n, sleep_req_n, deep_sleep_req_n} = 3'h7;
            suspend_powerdown_ack = 1'b0;
        end else if (sleep_req_n) begin
            sleep_req_n = 1'b0;
            gap_cnt = GAP;
        end else if (deep_sleep_req_n) begin
            deep_sleep_req_n = 1'b0;
            gap_cnt = GAP;
        end else suspend_powerdown_ack = 1'b1;
    end
endmodule

// ### testbench/ppsc_top_tb.sv
// self-checking bench of the platform power-state controller
`timescale 1ns/1ns
module ppsc_top_tb;
    logic clk = 1'b0, rstn = 1'b0, thermal_crit = 1'b0;
    logic supply_above_rise = 1'b0, supply_below_fall = 1'b1;
    logic power_button_in_n = 1'b1, external_enable_in = 1'b0;
    logic platform_reset_n_in = 1'b1, nonthermal_crit = 1'b0;
    logic rail_cmd_valid = 1'b0, bus_seen = 1'b0, map_seen = 1'b0;
    logic [7:0] rail_cmd = 8'h00, default_off_rails, got, notes[$];
    logic [1:0] want = 2'd0;
    logic shallow_sleep_req_n, sleep_req_n, deep_sleep_req_n;
    logic suspend_powerdown_ack, platform_reset_n_out, platform_reset_n_oe;
    logic core_power_good, host_rails_on, power_save_mode, bus_enable;
    logic bus_reset, regmap_reset, logic_defaults_reset, thermal_mon_enable;
    logic thermal_mon_standby, button_to_host_n, supply_valid, task_busy;
    logic task_done, dflt_seen = 1'b0;
    logic [2:0] task_list;
    logic [3:0] task_step;
    logic [5:0] power_state, last_st = 6'h01;
    int n_errors = 0, num_checks = 0;
    always #5 clk = ~clk;
    ppsc_top #(.BTN_HOLD_CYCLES(20)) i_ppsc_top (.clk, .rstn,
        .supply_above_rise, .supply_below_fall, .power_button_in_n,
        .external_enable_in, .platform_reset_n_in, .shallow_sleep_req_n,
        .sleep_req_n, .deep_sleep_req_n, .suspend_powerdown_ack,
        .thermal_crit, .nonthermal_crit, .rail_cmd_valid, .rail_cmd,
        .platform_reset_n_out, .platform_reset_n_oe, .core_power_good,
        .host_rails_on, .default_off_rails, .power_save_mode, .bus_enable,
        .bus_reset, .regmap_reset, .logic_defaults_reset,
        .thermal_mon_enable, .thermal_mon_standby, .button_to_host_n,
        .supply_valid, .task_busy, .task_list, .task_step, .task_done,
        .power_state);
    ppsc_host_model #(.GAP(12)) i_ppsc_host_model (.clk, .want,
        .shallow_sleep_req_n, .sleep_req_n, .deep_sleep_req_n,
        .suspend_powerdown_ack);
    task automatic fail(string m);
        n_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk(logic ok, string m);
        num_checks++;
        if (ok !== 1'b1) fail(m);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic void expect_st(logic [5:0] ps);
        logic run;
        run = ps inside {6'h04, 6'h08};
        notes.push_back({ps, !run, run});
    endfunction
    task automatic settle();
        for (int i = 0; i < 200 && notes.size() != 0; i++) tick(1);
        if (notes.size() != 0) fail("state change missing");
        tick(3);
    endtask
    task automatic boot(logic by_enable);
        if (by_enable) external_enable_in = 1'b1;
        else power_button_in_n = 1'b0;
        expect_st(6'h20);
        expect_st(6'h10);
        expect_st(6'h04);
        settle();
    endtask
    // an unexpected state change finds no note and counts as a mismatch
    always @(negedge clk) begin
        bus_seen = bus_seen | (bus_reset === 1'b1);
        map_seen = map_seen | (regmap_reset === 1'b1);
        dflt_seen = dflt_seen | (logic_defaults_reset === 1'b1);
        if (rstn && power_state !== last_st) begin
            got = {power_state, platform_reset_n_oe, core_power_good};
            last_st = power_state;
            num_checks++;
            if (notes.size() == 0 || notes[0] !== got) fail("state");
            if (notes.size() != 0) void'(notes.pop_front());
        end
    end
    initial begin
        #200000;
        fail("watchdog");
        give_verdict();
    end
    initial begin
        void'($urandom(32'hc148));
        tick(2);
        rstn = 1'b1;
        tick(2);
        {supply_above_rise, supply_below_fall} = 2'b10;
        expect_st(6'h02);
        settle();
        chk(map_seen, "no map reset");
        boot(1'b0);
        tick(40);
        chk(button_to_host_n === 1'b0, "button not passed");
        power_button_in_n = 1'b1;
        tick(5);
        chk(button_to_host_n === 1'b1, "button stuck");
        rail_cmd = 8'($urandom) | 8'h01;
        rail_cmd_valid = 1'b1;
        tick(1);
        rail_cmd_valid = 1'b0;
        tick(4);
        chk(default_off_rails === rail_cmd && host_rails_on, "rails");
        bus_seen = 1'b0;
        platform_reset_n_in = 1'b0;
        tick(2 + $urandom_range(4));
        platform_reset_n_in = 1'b1;
        tick(6);
        chk(bus_seen, "warm reset");
        want = 2'd1;
        expect_st(6'h08);
        settle();
        chk(power_save_mode && bus_enable, "shallow");
        chk(thermal_mon_enable && thermal_mon_standby, "slow");
        want = 2'd0;
        expect_st(6'h04);
        settle();
        thermal_crit = 1'b1;
        expect_st(6'h02);
        tick(1);
        thermal_crit = 1'b0;
        settle();
        chk(!host_rails_on && !platform_reset_n_out, "rails kept");
        boot(1'b1);
        external_enable_in = 1'b0;
        nonthermal_crit = 1'b1;
        expect_st(6'h02);
        tick(1);
        nonthermal_crit = 1'b0;
        tick(2);
        chk(task_busy && task_list === 3'h1, "cold-off");
        settle();
        boot(1'b0);
        power_button_in_n = 1'b1;
        want = 2'd2;
        expect_st(6'h10);
        expect_st(6'h20);
        expect_st(6'h02);
        settle();
        want = 2'd0;
        dflt_seen = 1'b0;
        {supply_above_rise, supply_below_fall} = 2'b01;
        expect_st(6'h01);
        settle();
        chk(dflt_seen, "defaults");
        give_verdict();
    end
endmodule
